// >>> inc/pocf_pkg.sv
package pocf_pkg;
   // register offsets (word index == byte address here, plain port)
   localparam logic [3:0] POCF_OFF_CTRL   = 4'h0;
   localparam logic [3:0] POCF_OFF_NDIV   = 4'h1;
   localparam logic [3:0] POCF_OFF_VCODIV = 4'h2;
   localparam logic [3:0] POCF_OFF_STAT   = 4'h3;
   // control field positions
   localparam int POCF_POS_OUT_EN   = 0;
   localparam int POCF_POS_GLB_EN   = 4;
   localparam int POCF_POS_CP_TRI   = 5;
   localparam int POCF_POS_CP_POL   = 6;
   localparam int POCF_POS_CP_GAIN  = 8;
   // reset values
   localparam logic [3:0]  POCF_RST_OUT_EN  = 4'h0;
   localparam logic        POCF_RST_GLB_EN  = 1'b1;
   localparam logic        POCF_RST_CP_TRI  = 1'b0;
   localparam logic        POCF_RST_CP_POL  = 1'b0;
   localparam logic [1:0]  POCF_RST_CP_GAIN = 2'h0;
   localparam logic [17:0] POCF_RST_NDIV    = 18'h002f8;
   localparam logic [7:0]  POCF_RST_VCODIV  = 8'h02;
   // charge pump gain multipliers
   localparam logic [5:0]  POCF_GAIN_X1  = 6'h01;
   localparam logic [5:0]  POCF_GAIN_X4  = 6'h04;
   localparam logic [5:0]  POCF_GAIN_X16 = 6'h10;
   localparam logic [5:0]  POCF_GAIN_X32 = 6'h20;

   typedef struct packed {
      logic       cp_tristate;
      logic       cp_positive;
      logic [5:0] cp_gain_mult;
   } pocf_cp_t;
endpackage

// >>> src/pocf_top.sv
// Contract
// [R1] global enable zero forces all outputs off
// [R2] output on needs own, global, pin enables
// [R3] tristate field floats charge pump when set
// [R4] polarity field: zero negative, one positive
// [R5] 18-bit N divider, zero invalid, default 760
// [R6] total feedback division is N times VCO divider
// [R7] gain code selects 1x, 4x, 16x, 32x
// [R8] clock buffer on when any output enabled
// [R9] host never writes zero to N field
module pocf_top
   import pocf_pkg::*;
#(
   parameter int N_OUT = 4
) (
   // clock and reset
   input  wire logic        i_sys_clk,
   input  wire logic        i_rst_n,
   // register port
   input  wire logic [3:0]  i_addr,
   input  wire logic [31:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [31:0] o_rdata,
   // pin
   input  wire logic        i_global_output_enable_pin,
   // controls to analog
   output logic [N_OUT-1:0] o_clock_output_enable,
   output logic             o_clock_buffer_on,
   output pocf_cp_t         o_cp,
   output logic [17:0]      o_n_divide,
   output logic [25:0]      o_n_total,
   output logic             o_n_invalid
);
   // status and gating words are laid out for exactly four outputs
   if (N_OUT != 4) begin
      $error("pocf_top: N_OUT must be 4");
   end

   logic [3:0]  per_output_enable;
   logic        global_output_enable;
   logic        charge_pump_tristate;
   logic        charge_pump_polarity;
   logic [1:0]  charge_pump_gain;
   logic [17:0] n_div;
   logic [7:0]  vco_div;
   logic        pin_meta;
   logic        pin_sync;

   function automatic logic [5:0] gain_mult(input logic [1:0] code);
      case (code)
         2'h0:    gain_mult = POCF_GAIN_X1;
         2'h1:    gain_mult = POCF_GAIN_X4;
         2'h2:    gain_mult = POCF_GAIN_X16;
         default: gain_mult = POCF_GAIN_X32;
      endcase
   endfunction

   function automatic logic reg_hit(input logic [3:0] addr, input logic [3:0] off);
      reg_hit = (addr == off);
   endfunction

   wire hit_ctrl = reg_hit(i_addr, POCF_OFF_CTRL);
   wire hit_ndiv = reg_hit(i_addr, POCF_OFF_NDIV);
   wire hit_vco  = reg_hit(i_addr, POCF_OFF_VCODIV);
   wire hit_stat = reg_hit(i_addr, POCF_OFF_STAT);
   wire wr_ctrl  = i_wr && hit_ctrl;
   wire wr_ndiv  = i_wr && hit_ndiv;
   wire wr_vco   = i_wr && hit_vco;
   // zero is refused so the counter never stalls
   wire ndiv_ok = (i_wdata[17:0] != 18'h00000); // [R5] [R9]

   // pin is asynchronous to the clock
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         pin_meta <= 1'b0;
         pin_sync <= 1'b0;
      end else begin
         pin_meta <= i_global_output_enable_pin;
         pin_sync <= pin_meta;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         per_output_enable    <= POCF_RST_OUT_EN;
         global_output_enable <= POCF_RST_GLB_EN;
         charge_pump_tristate <= POCF_RST_CP_TRI;
         charge_pump_polarity <= POCF_RST_CP_POL;
         charge_pump_gain     <= POCF_RST_CP_GAIN;
      end else if (wr_ctrl) begin
         per_output_enable    <= i_wdata[POCF_POS_OUT_EN +: 4];
         global_output_enable <= i_wdata[POCF_POS_GLB_EN];
         charge_pump_tristate <= i_wdata[POCF_POS_CP_TRI];
         charge_pump_polarity <= i_wdata[POCF_POS_CP_POL];
         charge_pump_gain     <= i_wdata[POCF_POS_CP_GAIN +: 2];
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         n_div   <= POCF_RST_NDIV;
         vco_div <= POCF_RST_VCODIV;
      end else begin
         if (wr_ndiv && ndiv_ok) n_div <= i_wdata[17:0]; // [R5]
         if (wr_vco) vco_div <= i_wdata[7:0];
      end
   end

   // gating is combinational, so the pin reaches the outputs one register cycle after sync
   wire [3:0] next_out_en = per_output_enable & {4{global_output_enable & pin_sync}}; // [R1] [R2]
   wire [25:0] next_total = 26'(n_div) * 26'(vco_div); // [R6]
   pocf_cp_t next_cp;
   assign next_cp.cp_tristate  = charge_pump_tristate; // [R3]
   assign next_cp.cp_positive  = charge_pump_polarity; // [R4]
   assign next_cp.cp_gain_mult = gain_mult(charge_pump_gain); // [R7]

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         o_clock_output_enable <= '0;
         o_clock_buffer_on     <= 1'b0;
         o_cp                  <= {POCF_RST_CP_TRI, POCF_RST_CP_POL, POCF_GAIN_X1};
         o_n_divide            <= POCF_RST_NDIV;
         o_n_total             <= 26'(POCF_RST_NDIV) * 26'(POCF_RST_VCODIV);
         o_n_invalid           <= 1'b0;
      end else begin
         o_clock_output_enable <= next_out_en;
         o_clock_buffer_on     <= |next_out_en; // [R8]
         o_cp                  <= next_cp;
         o_n_divide            <= n_div;
         o_n_total             <= next_total;
         o_n_invalid           <= (n_div == 18'h00000);
      end
   end

   wire [31:0] ctrl_word = {22'h0, charge_pump_gain, 1'b0, charge_pump_polarity,
                            charge_pump_tristate, global_output_enable, per_output_enable};
   wire [31:0] stat_word = {26'h0, pin_sync, |next_out_en, next_out_en};
   wire [31:0] next_rdata = hit_ctrl ? ctrl_word :
                            hit_ndiv ? {14'h0, n_div} :
                            hit_vco  ? {24'h0, vco_div} :
                            hit_stat ? stat_word : 32'h0;

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) o_rdata <= 32'h0;
      else o_rdata <= i_rd ? next_rdata : 32'h0;
   end

   chk_global_off: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // [R1]
      !global_output_enable |=> o_clock_output_enable == 4'h0)
      else $error("output on while global enable low");
   chk_out_gate: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // [R2]
      o_clock_output_enable[0] |-> $past(per_output_enable[0] && pin_sync && global_output_enable))
      else $error("output on without all enables");
   chk_cp_tri: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // [R3]
      $rose(charge_pump_tristate) |=> o_cp.cp_tristate)
      else $error("tristate not applied");
   chk_cp_pol: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // [R4]
      ##1 o_cp.cp_positive == $past(charge_pump_polarity))
      else $error("polarity mismatch");
   chk_ndiv_nz: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // [R5]
      wr_ndiv && !ndiv_ok |=> $stable(n_div) ##1 !o_n_invalid)
      else $error("zero N accepted");
   chk_n_total: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // [R6]
      ##1 o_n_total == $past(n_div) * $past(vco_div))
      else $error("total divide wrong");
   chk_cp_gain: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // [R7]
      charge_pump_gain == 2'h2 |=> o_cp.cp_gain_mult == 6'h10)
      else $error("gain 16x wrong");
   chk_buf_on: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // [R8]
      o_clock_buffer_on == (o_clock_output_enable != 4'h0))
      else $error("buffer state wrong");
   chk_pin_off: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // [R2]
      !pin_sync |=> o_clock_output_enable == 4'h0)
      else $error("output on while pin low");
   chk_own_off: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // [R2]
      ##1 (o_clock_output_enable & ~$past(per_output_enable)) == 4'h0)
      else $error("output on without own enable");
   chk_all_on: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // [R2]
      global_output_enable && pin_sync |=> o_clock_output_enable == $past(per_output_enable))
      else $error("enabled output stayed off");
   chk_glb_load: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // [R1]
      wr_ctrl |=> global_output_enable == $past(i_wdata[POCF_POS_GLB_EN]))
      else $error("global enable not stored");
   chk_cp_untri: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // [R3]
      $fell(charge_pump_tristate) |=> !o_cp.cp_tristate)
      else $error("tristate not released");
   chk_tri_load: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // [R3]
      wr_ctrl |=> charge_pump_tristate == $past(i_wdata[POCF_POS_CP_TRI]))
      else $error("tristate not stored");
   chk_pol_load: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // [R4]
      wr_ctrl |=> charge_pump_polarity == $past(i_wdata[POCF_POS_CP_POL]))
      else $error("polarity not stored");
   chk_ndiv_load: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // [R5]
      wr_ndiv && ndiv_ok |=> n_div == $past(i_wdata[17:0]))
      else $error("N value not stored");
   chk_ndiv_out: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // [R5]
      ##1 o_n_divide == $past(n_div))
      else $error("N output wrong");
   chk_ndiv_held: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // [R5]
      !wr_ndiv |=> $stable(n_div))
      else $error("N changed without write");
   chk_vco_load: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // [R6]
      wr_vco |=> vco_div == $past(i_wdata[7:0]))
      else $error("vco divider not stored");
   chk_gain_load: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // [R7]
      wr_ctrl |=> charge_pump_gain == $past(i_wdata[POCF_POS_CP_GAIN +: 2]))
      else $error("gain code not stored");
   chk_gain_one: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // [R7]
      charge_pump_gain == 2'h0 |=> o_cp.cp_gain_mult == POCF_GAIN_X1)
      else $error("gain 1x wrong");
   chk_gain_four: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // [R7]
      charge_pump_gain == 2'h1 |=> o_cp.cp_gain_mult == POCF_GAIN_X4)
      else $error("gain 4x wrong");
   chk_gain_max: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // [R7]
      charge_pump_gain == 2'h3 |=> o_cp.cp_gain_mult == POCF_GAIN_X32)
      else $error("gain 32x wrong");
   chk_buf_any: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // [R8]
      next_out_en != 4'h0 |=> o_clock_buffer_on)
      else $error("buffer off with output on");
   chk_buf_off: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // [R8]
      next_out_en == 4'h0 |=> !o_clock_buffer_on)
      else $error("buffer on with outputs off");
endmodule

// >>> verif/tb.sv
module tb import pocf_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic        i_sys_clk, i_rst_n, i_wr, i_rd, i_pin;
   logic [3:0]  i_addr, oe;
   logic [31:0] i_wdata, o_rdata, got;
   logic        buf_on, n_inv;
   pocf_cp_t    cp;
   logic [17:0] nd;
   logic [25:0] nt;
   int          miscompares, checked, cycles;
   logic [5:0]  mult [4] = '{POCF_GAIN_X1, POCF_GAIN_X4, POCF_GAIN_X16, POCF_GAIN_X32};
   pocf_top #(.N_OUT(4)) DUT (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_global_output_enable_pin(i_pin),
      .o_clock_output_enable(oe), .o_clock_buffer_on(buf_on), .o_cp(cp), .o_n_divide(nd),
      .o_n_total(nt), .o_n_invalid(n_inv));
   initial begin
      i_sys_clk = 1'b0;
      forever #4 i_sys_clk = ~i_sys_clk;
   end
   task automatic cmp(string nm, logic [31:0] exp, logic [31:0] seen);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // gap cycle between strobes keeps each strobe assigned once per step
   task automatic wr(logic [3:0] a, logic [31:0] d);
      @(posedge i_sys_clk);
      i_addr  <= a;
      i_wdata <= d;
      i_wr    <= 1'b1;
      @(posedge i_sys_clk);
      i_wr <= 1'b0;
   endtask
   task automatic rd(logic [3:0] a);
      @(posedge i_sys_clk);
      i_addr <= a;
      i_rd   <= 1'b1;
      @(posedge i_sys_clk);
      i_rd <= 1'b0;
      #1 got = o_rdata;
   endtask
   task automatic settle();
      repeat (2) @(posedge i_sys_clk);
      #1;
   endtask
   task automatic t_reset();
      cmp("n_divide", 32'(POCF_RST_NDIV), 32'(nd));
      cmp("n_total", 32'(POCF_RST_NDIV) * 32'(POCF_RST_VCODIV), 32'(nt));
      cmp("enables", 32'h0, 32'(oe));
      cmp("cp", {24'h0, 1'b0, 1'b0, POCF_GAIN_X1}, 32'(cp));
      rd(POCF_OFF_CTRL);
      cmp("ctrl", 32'h10, got);
      rd(POCF_OFF_NDIV);
      cmp("ndiv", 32'h2f8, got);
   endtask
   task automatic t_enable();
      wr(POCF_OFF_CTRL, 32'h1f);
      settle();
      cmp("enables", 32'hf, 32'(oe));
      cmp("buffer", 32'h1, 32'(buf_on));
      wr(POCF_OFF_CTRL, 32'h0f);
      settle();
      cmp("enables", 32'h0, 32'(oe));
      cmp("buffer", 32'h0, 32'(buf_on));
      wr(POCF_OFF_CTRL, 32'h19);
      settle();
      cmp("enables", 32'h9, 32'(oe));
      rd(POCF_OFF_STAT);
      cmp("status", 32'h39, got);
      @(posedge i_sys_clk);
      i_pin <= 1'b0;
      repeat (4) @(posedge i_sys_clk);
      #1 cmp("enables", 32'h0, 32'(oe));
      cmp("buffer", 32'h0, 32'(buf_on));
      rd(POCF_OFF_STAT);
      cmp("status", 32'h0, got);
      @(posedge i_sys_clk);
      i_pin <= 1'b1;
   endtask
   task automatic t_cp();
      for (int g = 0; g < 4; g++) begin
         // global enable kept at its default while the pump fields change
         wr(POCF_OFF_CTRL, 32'h10 | (32'(g) << 8) | (32'(g & 1) << 5) | (32'(g >> 1) << 6));
         settle();
         cmp("cp", {24'h0, 1'(g & 1), 1'(g >> 1), mult[g]}, 32'(cp));
      end
   endtask
   task automatic t_ndiv();
      wr(POCF_OFF_NDIV, 32'h3ffff);
      wr(POCF_OFF_VCODIV, 32'h5);
      settle();
      cmp("n_divide", 32'h3ffff, 32'(nd));
      cmp("n_total", 32'h3ffff * 5, 32'(nt));
      rd(POCF_OFF_VCODIV);
      cmp("vco_div", 32'h5, got);
      wr(POCF_OFF_NDIV, 32'h0);
      settle();
      cmp("n_divide", 32'h3ffff, 32'(nd));
      cmp("n_invalid", 32'h0, 32'(n_inv));
      wr(POCF_OFF_NDIV, 32'h1);
      settle();
      cmp("n_divide", 32'h1, 32'(nd));
      cmp("n_total", 32'h5, 32'(nt));
      rd(4'h9);
      cmp("unmapped", 32'h0, got);
   endtask
   task automatic end_of_test();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // whole run needs well under a few hundred cycles
   always @(posedge i_sys_clk) begin
      cycles++;
      if (cycles == 2000) begin
         miscompares++;
         end_of_test();
      end
   end
   initial begin
      i_rst_n <= 1'b0;
      i_wr    <= 1'b0;
      i_rd    <= 1'b0;
      i_pin   <= 1'b1;
      i_addr  <= 4'h0;
      i_wdata <= 32'h0;
      repeat (4) @(posedge i_sys_clk);
      i_rst_n <= 1'b1;
      settle();
      t_reset();
      t_enable();
      t_cp();
      t_ndiv();
      end_of_test();
   end
endmodule
